// ==== rtl/pdcs_device_ctl_sts.sv ====
// Device control and status registers behind a classic Wishbone slave
`timescale 1ns/100ps
`include "pdcs_regs.svh"

module pdcs_device_ctl_sts
	import pdcs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Wishbone slave
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Detected error events
	input wire logic corrErrIn,
	input wire logic nonfatalErrIn,
	input wire logic fatalErrIn,
	input wire logic unsupReqIn,
	// Error reports towards the message logic
	output logic corrReport,
	output logic nonfatalReport,
	output logic fatalReport,
	output logic unsupReport,
	// Traffic from the opposite side
	input wire logic inValid,
	input wire logic inRelaxed,
	input wire logic inNoSnoop,
	input wire logic [7:0] inTag,
	// Traffic onto this side
	output logic fwdValid,
	output logic fwdRelaxed,
	output logic fwdNoSnoop,
	output logic [7:0] fwdTag,
	// Attributes for locally generated requests
	output logic [7:0] genTag,
	output logic genNoSnoop,
	output logic [11:0] genReadBytes,
	output logic [11:0] maxPayloadBytes,
	// Interrupt
	output logic irq
);

	generate
		if (ADDR_W < 12) begin : g_bad_addr
			$error("ADDR_W must be at least 12");
		end
	endgenerate

	pdcs_half_t ctl_r;
	pdcs_half_t stsView;
	pdcs_err_t sts_r;
	pdcs_err_t irqSts_r;
	pdcs_err_t irqMsk_r;
	pdcs_err_t errVec;
	pdcs_err_t reportVec;
	logic [31:0] wbDat_r;
	logic [31:0] rdData;
	logic wbAck_r;
	logic req;
	logic done;
	logic [9:0] idx;
	logic hitCtl;
	logic hitSts;
	logic hitISts;
	logic hitIMsk;
	logic [15:0] wrBits;
	logic fwdValid_r;
	logic fwdRelaxed_r;
	logic fwdNoSnoop_r;
	logic [7:0] fwdTag_r;
	logic [7:0] genTag_r;
	logic genNoSnoop_r;
	logic [11:0] genReadBytes_r;
	logic [11:0] mpsBytes_r;
	logic irq_r;

	function automatic logic [11:0] mpsDecode(input logic [2:0] code);
		case (code)
			PDCS_MPS_256: mpsDecode = `PDCS_B256;
			PDCS_MPS_512: mpsDecode = `PDCS_B512;
			PDCS_MPS_1024: mpsDecode = `PDCS_B1024;
			PDCS_MPS_2048: mpsDecode = `PDCS_B2048;
			default: mpsDecode = `PDCS_B128;
		endcase
	endfunction

	assign errVec = {unsupReqIn, fatalErrIn, nonfatalErrIn, corrErrIn};
	assign idx = wb_adr_i[11:2];
	assign hitCtl = (idx == `PDCS_CTL_IDX);
	assign hitSts = (idx == `PDCS_STS_IDX);
	assign hitISts = (idx == `PDCS_ISTS_IDX);
	assign hitIMsk = (idx == `PDCS_IMSK_IDX);
	// New request, and the edge at which the master sees ack
	assign req = wb_cyc_i && wb_stb_i && !wbAck_r;
	assign done = wb_cyc_i && wb_stb_i && wbAck_r;
	assign wrBits = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & wb_dat_i[15:0];

	// Read-only status bits stay zero
	assign stsView = {12'h000, sts_r};

	always_comb begin
		rdData = 32'h0000_0000;
		if (hitCtl) begin
			rdData[15:0] = ctl_r & `PDCS_CTL_WMASK;
		end else if (hitSts) begin
			rdData[15:0] = stsView;
		end else if (hitISts) begin
			rdData[3:0] = irqSts_r;
		end else if (hitIMsk) begin
			rdData[3:0] = irqMsk_r;
		end
	end

	// Bus answer: one wait state, unmapped reads give zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wbAck_r <= 1'b0;
		end else begin
			wbAck_r <= req;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wbDat_r <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			wbDat_r <= rdData;
		end else if (wbAck_r) begin
			wbDat_r <= 32'h0000_0000;
		end
	end

	// Control register; fixed and reserved bits never store
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctl_r <= `PDCS_CTL_RST;
		end else if (done && wb_we_i && hitCtl) begin
			ctl_r <= (ctl_r & ~({{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `PDCS_CTL_WMASK))
				| (wrBits & `PDCS_CTL_WMASK);
		end
	end

	// Per error: sticky status, interrupt status and gated report
	genvar gi;
	generate
		for (gi = 0; gi < `PDCS_NERR; gi++) begin : g_err
			// Set beats a write-one clear in the same cycle
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					sts_r[gi] <= 1'b0;
				end else if (errVec[gi]) begin
					sts_r[gi] <= 1'b1;
				end else if (done && wb_we_i && hitSts && wrBits[gi]) begin
					sts_r[gi] <= 1'b0;
				end
			end

			// Only clear what the read actually returned, so a late event survives
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					irqSts_r[gi] <= 1'b0;
				end else if (errVec[gi]) begin
					irqSts_r[gi] <= 1'b1;
				end else if (done && !wb_we_i && hitISts && wbDat_r[gi]) begin
					irqSts_r[gi] <= 1'b0;
				end
			end

			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					irqMsk_r[gi] <= 1'b0;
				end else if (done && wb_we_i && hitIMsk && wb_sel_i[0]) begin
					irqMsk_r[gi] <= wb_dat_i[gi];
				end
			end

			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					reportVec[gi] <= 1'b0;
				end else begin
					reportVec[gi] <= errVec[gi] && ctl_r[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irqSts_r & irqMsk_r);
		end
	end

	// Pass-through stage towards this side; relaxed ordering passes only while enabled
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fwdValid_r <= 1'b0;
			fwdRelaxed_r <= 1'b0;
			fwdNoSnoop_r <= 1'b0;
			fwdTag_r <= 8'h00;
		end else begin
			fwdValid_r <= inValid;
			fwdRelaxed_r <= inRelaxed && ctl_r[`PDCS_CTL_RO];
			fwdNoSnoop_r <= inNoSnoop;
			fwdTag_r <= inTag;
		end
	end

	// Generated requests: zero tag, no snoop suppression, small reads
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			genTag_r <= 8'h00;
			genNoSnoop_r <= 1'b0;
			genReadBytes_r <= `PDCS_B128;
		end else begin
			genTag_r <= 8'h00;
			genNoSnoop_r <= 1'b0;
			genReadBytes_r <= `PDCS_B128;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mpsBytes_r <= `PDCS_B128;
		end else begin
			mpsBytes_r <= mpsDecode(ctl_r[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB]);
		end
	end

	assign wb_dat_o = wbDat_r;
	assign wb_ack_o = wbAck_r;
	assign corrReport = reportVec[0];
	assign nonfatalReport = reportVec[1];
	assign fatalReport = reportVec[2];
	assign unsupReport = reportVec[3];
	assign fwdValid = fwdValid_r;
	assign fwdRelaxed = fwdRelaxed_r;
	assign fwdNoSnoop = fwdNoSnoop_r;
	assign fwdTag = fwdTag_r;
	assign genTag = genTag_r;
	assign genNoSnoop = genNoSnoop_r;
	assign genReadBytes = genReadBytes_r;
	assign maxPayloadBytes = mpsBytes_r;
	assign irq = irq_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_ctlWrite;
		done && wb_we_i && hitCtl;
	endsequence

	property p_report;
		corrErrIn && ctl_r[0] |=> corrReport;
	endproperty
	a_report: assert property (p_report) else $error("correctable report missing");

	property p_urReport;
		unsupReqIn && !ctl_r[3] |=> !unsupReport;
	endproperty
	a_urReport: assert property (p_urReport) else $error("ur reported while disabled");

	property p_roForce;
		!ctl_r[`PDCS_CTL_RO] |=> !fwdRelaxed;
	endproperty
	a_roForce: assert property (p_roForce) else $error("relaxed order leaked");

	property p_roKeep;
		ctl_r[`PDCS_CTL_RO] |=> fwdRelaxed == $past(inRelaxed);
	endproperty
	a_roKeep: assert property (p_roKeep) else $error("relaxed order altered");

	property p_mps;
		##1 maxPayloadBytes == ($past(ctl_r[7:5]) > 3'h4 ? `PDCS_B128 : `PDCS_B128 << $past(ctl_r[7:5]));
	endproperty
	a_mps: assert property (p_mps) else $error("payload decode wrong");

	property p_mpsRsv;
		ctl_r[7:5] > 3'h4 |=> maxPayloadBytes == 12'h080;
	endproperty
	a_mpsRsv: assert property (p_mpsRsv) else $error("reserved payload code not 128");

	property p_tag;
		##1 fwdTag == $past(inTag) && genTag == 8'h00;
	endproperty
	a_tag: assert property (p_tag) else $error("tag handling wrong");

	property p_ctlRo;
		wbAck_r && hitCtl && !wb_we_i |-> wb_dat_o[10:9] == 2'b00 && wb_dat_o[15] == 1'b0;
	endproperty
	a_ctlRo: assert property (p_ctlRo) else $error("fixed control bits not zero");

	property p_noSnoop;
		##1 genNoSnoop == 1'b0 && fwdNoSnoop == $past(inNoSnoop);
	endproperty
	a_noSnoop: assert property (p_noSnoop) else $error("snoop attribute wrong");

	property p_mrrsHold;
		!(done && wb_we_i && hitCtl) |=> $stable(ctl_r[14:12]);
	endproperty
	a_mrrsHold: assert property (p_mrrsHold) else $error("read size field moved");

	sequence s_errSeen;
		fatalErrIn ##1 sts_r[2];
	endsequence

	property p_stsSet;
		fatalErrIn |-> s_errSeen;
	endproperty
	a_stsSet: assert property (p_stsSet) else $error("fatal error not latched");

	property p_urSet;
		unsupReqIn |=> sts_r[3] && irqSts_r[3];
	endproperty
	a_urSet: assert property (p_urSet) else $error("ur not latched");

	property p_stsRo;
		wbAck_r && hitSts && !wb_we_i |-> wb_dat_o[15:4] == 12'h000;
	endproperty
	a_stsRo: assert property (p_stsRo) else $error("status fixed bits not zero");

	property p_w1cZero;
		done && wb_we_i && hitSts && !wrBits[0] && sts_r[0] |=> sts_r[0];
	endproperty
	a_w1cZero: assert property (p_w1cZero) else $error("zero write cleared status");

	property p_nfReport;
		nonfatalErrIn && ctl_r[1] |=> nonfatalReport;
	endproperty
	a_nfReport: assert property (p_nfReport) else $error("non-fatal report missing");

	property p_fatalReport;
		fatalErrIn && ctl_r[2] |=> fatalReport;
	endproperty
	a_fatalReport: assert property (p_fatalReport) else $error("fatal report missing");

	property p_urOn;
		unsupReqIn && ctl_r[3] |=> unsupReport;
	endproperty
	a_urOn: assert property (p_urOn) else $error("ur report missing");

	property p_auxPm;
		wbAck_r && hitCtl && !wb_we_i |-> wb_dat_o[10] == 1'b0;
	endproperty
	a_auxPm: assert property (p_auxPm) else $error("aux power enable not zero");

	property p_mrrsWrite;
		s_ctlWrite ##0 wb_sel_i[1] |=> ctl_r[14:12] == $past(wb_dat_i[14:12]);
	endproperty
	a_mrrsWrite: assert property (p_mrrsWrite) else $error("read size field not stored");

	property p_genSize;
		##1 genReadBytes == `PDCS_B128;
	endproperty
	a_genSize: assert property (p_genSize) else $error("generated read size wrong");

	property p_ctlFixed;
		s_ctlWrite |=> ctl_r[15] == 1'b0 && ctl_r[10:9] == 2'b00;
	endproperty
	a_ctlFixed: assert property (p_ctlFixed) else $error("fixed control bits stored");

	property p_w1cClear;
		done && wb_we_i && hitSts && wrBits[1] && !nonfatalErrIn |=> !sts_r[1];
	endproperty
	a_w1cClear: assert property (p_w1cClear) else $error("one write left status set");

endmodule // pdcs_device_ctl_sts

// ==== rtl/pdcs_regs.svh ====
// Offsets, field positions, reset values and counts of the device control and status bank
`ifndef PDCS_REGS_SVH
`define PDCS_REGS_SVH

// Register indices; byte address is four times the index
`define PDCS_CTL_IDX 10'h048
`define PDCS_STS_IDX 10'h04a
`define PDCS_ISTS_IDX 10'h060
`define PDCS_IMSK_IDX 10'h061

// Control fields
`define PDCS_CTL_RO 4
`define PDCS_CTL_MPS_LSB 5
`define PDCS_CTL_MPS_MSB 7
`define PDCS_CTL_RST 16'h2010
`define PDCS_CTL_WMASK 16'h79ff

// Status fields
`define PDCS_STS_W1C 16'h000f
`define PDCS_NERR 4

// Payload and request sizes in bytes
`define PDCS_B128 12'h080
`define PDCS_B256 12'h100
`define PDCS_B512 12'h200
`define PDCS_B1024 12'h400
`define PDCS_B2048 12'h800

`endif

// ==== rtl/pdcs_pkg.sv ====
// Types shared by the device control and status bank
package pdcs_pkg;
	typedef logic [15:0] pdcs_half_t;
	typedef logic [3:0] pdcs_err_t;
	typedef enum logic [2:0] {
		PDCS_MPS_128 = 3'h0,
		PDCS_MPS_256 = 3'h1,
		PDCS_MPS_512 = 3'h2,
		PDCS_MPS_1024 = 3'h3,
		PDCS_MPS_2048 = 3'h4
	} pdcs_mps_t;
endpackage

// ==== test/pdcs_host.sv ====
// Host configuration software model driving the register bus
`timescale 1ns/100ps

module pdcs_host (
	// Clock
	input wire logic core_clk,
	// Wishbone master
	output logic [11:0] adr,
	output logic [31:0] wdat,
	output logic [3:0] sel,
	output logic we,
	output logic stb,
	output logic cyc,
	input wire logic [31:0] rdat,
	input wire logic ack
);
	initial begin
		{cyc, stb, we, adr, wdat, sel} = '0;
	end

	// One request at a time, held until the ack edge; no count of cycles assumed
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'h3};
		do @(posedge core_clk); while (ack !== 1'b1);
		q = rdat;
		// Released data is inverted so a stale value never looks valid
		{cyc, stb, we, wdat} <= {3'b000, ~d};
		@(posedge core_clk);
	endtask
endmodule // pdcs_host

// ==== test/tb.sv ====
// Self-checking bench of the device control and status bank
`timescale 1ns/100ps
`include "pdcs_regs.svh"

module tb;
	import pdcs_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [3:0] sel;
	logic [3:0] err = 4'h0;
	logic [3:0] rep;
	logic we, stb, cyc, ack, irq;
	logic inValid = 1'b0, inRelaxed = 1'b0, inNoSnoop = 1'b0;
	logic [7:0] inTag = 8'h00;
	logic fwdValid, fwdRelaxed, fwdNoSnoop, genNoSnoop;
	logic [7:0] fwdTag, genTag;
	logic [11:0] genReadBytes, mpb;
	int failures = 0;
	int samples_checked = 0;

	always #5 core_clk = ~core_clk;

	pdcs_host i_host (.core_clk(core_clk), .adr(adr), .wdat(wdat), .sel(sel), .we(we), .stb(stb), .cyc(cyc),
		.rdat(rdat), .ack(ack));

	pdcs_device_ctl_sts #(.ADDR_W(12)) i_dut (.core_clk(core_clk), .rstn(rstn), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_dat_o(rdat),
		.wb_ack_o(ack), .corrErrIn(err[0]), .nonfatalErrIn(err[1]), .fatalErrIn(err[2]), .unsupReqIn(err[3]),
		.corrReport(rep[0]), .nonfatalReport(rep[1]), .fatalReport(rep[2]), .unsupReport(rep[3]),
		.inValid(inValid), .inRelaxed(inRelaxed), .inNoSnoop(inNoSnoop), .inTag(inTag), .fwdValid(fwdValid),
		.fwdRelaxed(fwdRelaxed), .fwdNoSnoop(fwdNoSnoop), .fwdTag(fwdTag), .genTag(genTag),
		.genNoSnoop(genNoSnoop), .genReadBytes(genReadBytes), .maxPayloadBytes(mpb), .irq(irq));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		i_host.xfer(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		i_host.xfer(1'b0, a, 32'h0, d);
	endtask

	// Reserved codes fall back to the smallest payload
	function automatic logic [11:0] mpsBytes(input logic [2:0] c);
		return (c > 3'h4) ? `PDCS_B128 : `PDCS_B128 << c;
	endfunction

	task automatic pulse(input int k, input logic [3:0] en);
		@(posedge core_clk);
		err <= 4'h1 << k;
		@(posedge core_clk);
		err <= 4'h0;
		#1 chk("report", {28'h0, en & (4'h1 << k)}, {28'h0, rep});
	endtask

	task automatic end_sim();
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		logic [3:0] en;
		void'($urandom(32'hafa9));
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		rd(12'h120, q);
		chk("ctl", 32'h2010, q);
		chk("gen", 32'h00040000, {8'h0, genNoSnoop, genReadBytes, 3'h0, genTag});
		wr(12'h120, 32'hffff);
		rd(12'h120, q);
		chk("ctl", 32'h79ff, q);
		wr(12'h128, 32'hfff0);
		rd(12'h128, q);
		chk("sts", 32'h0, q);
		wr(12'h3fc, 32'hffff);
		rd(12'h3fc, q);
		chk("unmapped", 32'h0, q);
		for (int i = 0; i < 8; i++) begin
			wr(12'h120, {24'h0, i[2:0], 5'h10});
			@(posedge core_clk);
			#1 chk("payload", {20'h0, mpsBytes(i[2:0])}, {20'h0, mpb});
		end
		for (int r = 0; r < 2; r++) begin
			wr(12'h120, {27'h0, r[0], 4'h0});
			repeat (20) begin
				@(posedge core_clk);
				{inValid, inRelaxed, inNoSnoop, inTag} <= 11'($urandom);
				@(posedge core_clk);
				#1 chk("fwd", {21'h0, inValid, inRelaxed & r[0], inNoSnoop, inTag},
					{21'h0, fwdValid, fwdRelaxed, fwdNoSnoop, fwdTag});
			end
		end
		for (int e = 0; e < 2; e++) begin
			en = e[0] ? 4'hf : 4'h0;
			wr(12'h120, {28'h0, en});
			for (int k = 0; k < 4; k++) begin
				pulse(k, en);
				rd(12'h128, q);
				chk("sts", 32'h1 << k, q);
				wr(12'h128, 32'h0);
				rd(12'h128, q);
				chk("sts", 32'h1 << k, q);
				wr(12'h128, 32'h1 << k);
				rd(12'h128, q);
				chk("sts", 32'h0, q);
				chk("irq", 32'h0, {31'h0, irq});
			end
		end
		// Interrupt status read clears what earlier events left behind
		rd(12'h180, q);
		chk("irqsts", 32'hf, q);
		wr(12'h184, 32'h4);
		rd(12'h184, q);
		chk("mask", 32'h4, q);
		pulse(0, 4'hf);
		repeat (2) @(posedge core_clk);
		#1 chk("irq", 32'h0, {31'h0, irq});
		pulse(2, 4'hf);
		repeat (2) @(posedge core_clk);
		#1 chk("irq", 32'h1, {31'h0, irq});
		rd(12'h180, q);
		chk("irqsts", 32'h5, q);
		@(posedge core_clk);
		#1 chk("irq", 32'h0, {31'h0, irq});
		rd(12'h180, q);
		chk("irqsts", 32'h0, q);
		end_sim();
	end

	// Whole sequence needs a few hundred cycles
	initial begin
		#100000;
		failures++;
		end_sim();
	end
endmodule // tb
